// ===== src/ecg_pkg.sv
// ecg_pkg: constants and types shared by the encoder counter / gpio unit.
// assumes a 32-bit register port with byte addresses on an 8-bit address.
package ecg_pkg;

  // register byte offsets
  localparam logic [7:0] ECG_CNT0_OFS     = 8'h00;
  localparam logic [7:0] ECG_CNT1_OFS     = 8'h04;
  localparam logic [7:0] ECG_CNT2_OFS     = 8'h08;
  localparam logic [7:0] ECG_MODE_OFS     = 8'h0C;
  localparam logic [7:0] ECG_FB_SEL_OFS   = 8'h10;
  localparam logic [7:0] ECG_FB_RES_OFS   = 8'h14;
  localparam logic [7:0] ECG_DIN_OFS      = 8'h18;
  localparam logic [7:0] ECG_DOUT_OFS     = 8'h1C;
  localparam logic [7:0] ECG_DA_CFG_OFS   = 8'h20;
  localparam logic [7:0] ECG_DA_VAL0_OFS  = 8'h24;
  localparam logic [7:0] ECG_DA_VAL1_OFS  = 8'h28;
  localparam logic [7:0] ECG_AD_GAIN_OFS  = 8'h2C;
  localparam logic [7:0] ECG_SELF_SRC_OFS = 8'h30;
  localparam logic [7:0] ECG_DA_TRIM_OFS  = 8'h34;
  localparam logic [7:0] ECG_AD_TRIM_OFS  = 8'h38;
  localparam logic [7:0] ECG_NV_CTRL_OFS  = 8'h3C;

  // field positions
  localparam int ECG_FB_EN_BIT   = 8;
  localparam int ECG_FB_AXIS_LSB = 4;
  localparam int ECG_TRIM_STEP_LSB = 8;
  localparam int ECG_NV_SAVE_BIT = 0;
  localparam int ECG_NV_LOAD_BIT = 1;

  // values after reset, and the last trim byte index
  localparam logic [7:0]  ECG_TRIM_MID   = 8'h80;
  localparam logic [31:0] ECG_FB_RES_RST = 32'h0000_0000;
  localparam logic [2:0]  ECG_NV_LAST    = 3'h7;

  // velocity profile scaling: full scale rpm onto full scale code
  localparam int ECG_RPM_FS  = 3000;
  localparam int ECG_CODE_FS = 32767;

  typedef enum logic [1:0] {
    ECG_MODE_QUAD = 2'b00,
    ECG_MODE_DUAL = 2'b01,
    ECG_MODE_PDIR = 2'b10
  } ecg_mode_t;

  typedef enum logic [1:0] {
    ECG_GAIN_X1 = 2'b00,
    ECG_GAIN_X2 = 2'b01,
    ECG_GAIN_X4 = 2'b10
  } ecg_gain_t;

  typedef enum logic [1:0] {
    ECG_SRC_REF5 = 2'b00,
    ECG_SRC_GND  = 2'b01,
    ECG_SRC_AO0  = 2'b10,
    ECG_SRC_AO1  = 2'b11
  } ecg_src_t;

  // gray along idle -> load -> idle and idle -> save -> idle
  typedef enum logic [1:0] {
    ECG_NV_IDLE = 2'b00,
    ECG_NV_LOAD = 2'b01,
    ECG_NV_SAVE = 2'b10
  } ecg_nv_t;

endpackage

// ===== src/ecg_enc_counter.sv
// ecg_enc_counter: one incremental encoder counter with three input modes.
// assumes encoder pins already synchronous to clk_i.
`timescale 1ns/1ps
module ecg_enc_counter import ecg_pkg::*; #(
  parameter int CW = 32
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rstn_i,
  // encoder pins
  input  wire logic          a_i,
  input  wire logic          b_i,
  input  wire logic          z_i,
  // control
  input  wire logic [1:0]    mode_i,
  input  wire logic          load_i,
  input  wire logic [CW-1:0] load_val_i,
  // count
  output logic [CW-1:0]      count_o
);

  logic          a_q;
  logic          b_q;
  logic          z_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          inc;
  logic          dec;

  // edge and phase detection against last sample
  wire a_rise    = a_i & ~a_q;
  wire b_rise    = b_i & ~b_q;
  wire z_rise    = z_i & ~z_q;
  wire quad_step = (a_i ^ a_q) ^ (b_i ^ b_q); // both moving is an illegal jump
  wire quad_up   = a_i ^ b_q;

  // direction decode per mode
  always_comb begin
    inc = 1'b0;
    dec = 1'b0;
    case (mode_i)
      ECG_MODE_QUAD: begin
        inc = quad_step & quad_up;
        dec = quad_step & ~quad_up;
      end
      ECG_MODE_DUAL: begin
        inc = a_rise & ~b_rise;
        dec = b_rise & ~a_rise;
      end
      ECG_MODE_PDIR: begin
        inc = a_rise & b_i;
        dec = a_rise & ~b_i;
      end
      default: begin
        inc = 1'b0;
        dec = 1'b0;
      end
    endcase
  end

  // host load wins so a written value is never lost to a pulse
  always_comb begin
    if (load_i) begin
      cnt_d = load_val_i;
    end else if (z_rise) begin
      cnt_d = '0;
    end else if (inc) begin
      cnt_d = cnt_q + CW'(1);
    end else if (dec) begin
      cnt_d = cnt_q - CW'(1);
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_q   <= 1'b0;
      b_q   <= 1'b0;
      z_q   <= 1'b0;
      cnt_q <= '0;
    end else begin
      a_q   <= a_i;
      b_q   <= b_i;
      z_q   <= z_i;
      cnt_q <= cnt_d;
    end
  end

  assign count_o = cnt_q;

endmodule

// ===== src/ecg_unit.sv
// ecg_unit: encoder counters, isolated dio, analog mode control and
// calibration trim store of a motion card.
// assumes a simple strobe register port and an external byte-wide
// nonvolatile memory controller with a req/ack handshake.
`timescale 1ns/1ps
module ecg_unit import ecg_pkg::*; #(
  parameter int NCNT = 3,
  parameter int CW   = 32,
  parameter int VW   = 16,
  parameter int NAX  = 4
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // register port
  input  wire logic [7:0]        addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic [31:0]            rdata_o,
  // encoder inputs, one bit per counter
  input  wire logic [NCNT-1:0]   count_input_first_i,
  input  wire logic [NCNT-1:0]   count_input_second_i,
  input  wire logic [NCNT-1:0]   index_input_i,
  // position feedback assignment
  output logic                   fb_valid_o,
  output logic [NAX-1:0]         fb_axis_o,
  output logic [CW-1:0]          fb_position_o,
  output logic [31:0]            fb_resolution_o,
  // isolated digital io
  input  wire logic [1:0]        din_i,
  output logic [1:0]             dout_o,
  // analog outputs, channel one in the upper half
  input  wire logic [2*VW-1:0]   cmd_vel_i,
  output logic [2*VW-1:0]        ao_code_o,
  // analog input control
  output logic [3:0]             ad_gain_o,
  output logic [1:0]             self_check_src_o,
  // calibration trims, step 0 in the low byte
  output logic [31:0]            ao_trim_o,
  output logic [31:0]            ad_trim_o,
  // nonvolatile memory handshake
  output logic                   nv_req_o,
  output logic                   nv_we_o,
  output logic [2:0]             nv_addr_o,
  output logic [7:0]             nv_wdata_o,
  input  wire logic              nv_ack_i,
  input  wire logic [7:0]        nv_rdata_i
);

  // ---------------------------------------------------------------
  // register state
  logic [2*NCNT-1:0] mode_q;
  logic [8:0]        fb_sel_q;
  logic [31:0]       fb_res_q;
  logic [1:0]        dout_q;
  logic [1:0]        ao_cfg_q;
  logic [VW-1:0]     ao_val_q [2];
  logic [3:0]        gain_q;
  logic [1:0]        src_q;
  logic [7:0]        trim_q [8];
  logic [31:0]       rdata_q;
  logic [CW-1:0]     count [NCNT];

  // nonvolatile sequencer state
  ecg_nv_t           nv_st_q;
  ecg_nv_t           nv_st_d;
  logic [2:0]        nv_idx_q;
  logic              nv_req_q;
  logic              nv_loaded_q;

  // output flops
  logic              fb_valid_q;
  logic [NAX-1:0]    fb_axis_q;
  logic [CW-1:0]     fb_pos_q;
  logic [VW-1:0]     ao_code_q [2];

  // ---------------------------------------------------------------
  // address decode
  wire sel_mode  = (addr_i == ECG_MODE_OFS);
  wire sel_fbs   = (addr_i == ECG_FB_SEL_OFS);
  wire sel_fbr   = (addr_i == ECG_FB_RES_OFS);
  wire sel_dout  = (addr_i == ECG_DOUT_OFS);
  wire sel_acfg  = (addr_i == ECG_DA_CFG_OFS);
  wire sel_aval0 = (addr_i == ECG_DA_VAL0_OFS);
  wire sel_aval1 = (addr_i == ECG_DA_VAL1_OFS);
  wire sel_gain  = (addr_i == ECG_AD_GAIN_OFS);
  wire sel_src   = (addr_i == ECG_SELF_SRC_OFS);
  wire sel_atrim = (addr_i == ECG_DA_TRIM_OFS);
  wire sel_dtrim = (addr_i == ECG_AD_TRIM_OFS);
  wire sel_nv    = (addr_i == ECG_NV_CTRL_OFS);

  wire nv_busy   = (nv_st_q != ECG_NV_IDLE);
  wire nv_save   = wr_i & sel_nv & wdata_i[ECG_NV_SAVE_BIT] & ~nv_busy;
  wire nv_load   = wr_i & sel_nv & wdata_i[ECG_NV_LOAD_BIT] & ~nv_busy;
  // software trim writes are refused while the memory walk runs so a save stays coherent
  wire trim_we   = wr_i & (sel_atrim | sel_dtrim) & ~nv_busy;
  wire [2:0] trim_widx = {sel_dtrim, wdata_i[ECG_TRIM_STEP_LSB +: 2]};

  // gain code 2'b11 is not a legal gain; that lane keeps its old setting
  wire [1:0] gain_w0 = (wdata_i[1:0] == 2'b11) ? gain_q[1:0] : wdata_i[1:0];
  wire [1:0] gain_w1 = (wdata_i[3:2] == 2'b11) ? gain_q[3:2] : wdata_i[3:2];

  // ---------------------------------------------------------------
  // encoder counters
  genvar gi;
  generate
    for (gi = 0; gi < NCNT; gi++) begin : g_cnt
      wire ld = wr_i & (addr_i == 8'(gi * 4));
      ecg_enc_counter #(
        .CW(CW)
      ) u_cnt (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .a_i        (count_input_first_i[gi]),
        .b_i        (count_input_second_i[gi]),
        .z_i        (index_input_i[gi]),
        .mode_i     (mode_q[2*gi +: 2]),
        .load_i     (ld),
        .load_val_i (wdata_i[CW-1:0]),
        .count_o    (count[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // control registers written by software
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q   <= '0;
      fb_sel_q <= '0;
      fb_res_q <= ECG_FB_RES_RST;
      dout_q   <= '0;
      ao_cfg_q <= '0;
      gain_q   <= '0;
      src_q    <= ECG_SRC_REF5;
    end else if (wr_i) begin
      if (sel_mode) begin
        mode_q <= wdata_i[2*NCNT-1:0];
      end
      if (sel_fbs) begin
        fb_sel_q <= wdata_i[8:0];
      end
      if (sel_fbr) begin
        fb_res_q <= wdata_i;
      end
      if (sel_dout) begin
        dout_q <= wdata_i[1:0];
      end
      if (sel_acfg) begin
        ao_cfg_q <= wdata_i[1:0];
      end
      if (sel_gain) begin
        gain_q <= {gain_w1, gain_w0};
      end
      if (sel_src) begin
        src_q <= wdata_i[1:0];
      end
    end
  end

  // direct analog values, held regardless of mode
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ao_val_q[0] <= '0;
      ao_val_q[1] <= '0;
    end else begin
      if (wr_i & sel_aval0) begin
        ao_val_q[0] <= wdata_i[VW-1:0];
      end
      if (wr_i & sel_aval1) begin
        ao_val_q[1] <= wdata_i[VW-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // analog output path, clamp before scaling keeps the product small
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ao
      wire signed [VW-1:0] vel = cmd_vel_i[gi*VW +: VW];
      wire signed [31:0]   v32 = 32'(vel);
      wire signed [31:0]   vcl = (v32 > ECG_RPM_FS)  ? ECG_RPM_FS :
                                 (v32 < -ECG_RPM_FS) ? -ECG_RPM_FS : v32;
      wire signed [31:0]   vsc = (vcl * ECG_CODE_FS) / ECG_RPM_FS;
      wire [VW-1:0]        nxt = ao_cfg_q[gi] ? vsc[VW-1:0] : ao_val_q[gi];

      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          ao_code_q[gi] <= '0;
        end else begin
          ao_code_q[gi] <= nxt;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // position feedback follows the chosen counter every cycle
  wire [1:0]    fb_cnt = fb_sel_q[1:0];
  wire [CW-1:0] fb_src = (fb_cnt < 2'(NCNT)) ? count[fb_cnt] : '0;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fb_valid_q <= 1'b0;
      fb_axis_q  <= '0;
      fb_pos_q   <= '0;
    end else begin
      fb_valid_q <= fb_sel_q[ECG_FB_EN_BIT] & (fb_cnt < 2'(NCNT));
      fb_axis_q  <= fb_sel_q[ECG_FB_AXIS_LSB +: NAX];
      fb_pos_q   <= fb_src;
    end
  end

  // ---------------------------------------------------------------
  // nonvolatile sequencer: one byte per handshake, index 0..7
  always_comb begin
    nv_st_d = nv_st_q;
    case (nv_st_q)
      ECG_NV_IDLE: begin
        if (nv_save) begin
          nv_st_d = ECG_NV_SAVE;
        end else if (nv_load) begin
          nv_st_d = ECG_NV_LOAD;
        end
      end
      ECG_NV_LOAD, ECG_NV_SAVE: begin
        if (nv_ack_i & nv_req_q & (nv_idx_q == ECG_NV_LAST)) begin
          nv_st_d = ECG_NV_IDLE;
        end
      end
      default: begin
        nv_st_d = ECG_NV_IDLE;
      end
    endcase
  end

  // reset enters the load walk so trims come back at power up
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nv_st_q     <= ECG_NV_LOAD;
      nv_idx_q    <= '0;
      nv_req_q    <= 1'b0;
      nv_loaded_q <= 1'b0;
    end else begin
      nv_st_q <= nv_st_d;
      if (!nv_busy) begin
        nv_idx_q <= '0;
        nv_req_q <= nv_save | nv_load;
      end else if (nv_req_q & nv_ack_i) begin
        nv_idx_q <= nv_idx_q + 3'h1;
        nv_req_q <= (nv_idx_q != ECG_NV_LAST);
        if ((nv_idx_q == ECG_NV_LAST) && (nv_st_q == ECG_NV_LOAD)) begin
          nv_loaded_q <= 1'b1;
        end
      end else begin
        nv_req_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // trim store: bytes 0..3 analog output steps, 4..7 analog input steps
  generate
    for (gi = 0; gi < 8; gi++) begin : g_trim
      wire ld_nv = (nv_st_q == ECG_NV_LOAD) & nv_req_q & nv_ack_i &
                   (nv_idx_q == 3'(gi));
      wire ld_sw = trim_we & (trim_widx == 3'(gi));

      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          trim_q[gi] <= ECG_TRIM_MID;
        end else if (ld_nv) begin
          trim_q[gi] <= nv_rdata_i;
        end else if (ld_sw) begin
          trim_q[gi] <= wdata_i[7:0];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // read mux, unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_i == ECG_CNT0_OFS) begin
      rd_mux = 32'(count[0]);
    end else if (addr_i == ECG_CNT1_OFS) begin
      rd_mux = 32'(count[1]);
    end else if (addr_i == ECG_CNT2_OFS) begin
      rd_mux = 32'(count[2]);
    end else if (sel_mode) begin
      rd_mux = 32'(mode_q);
    end else if (sel_fbs) begin
      rd_mux = 32'(fb_sel_q);
    end else if (sel_fbr) begin
      rd_mux = fb_res_q;
    end else if (addr_i == ECG_DIN_OFS) begin
      rd_mux = 32'(din_i);
    end else if (sel_dout) begin
      rd_mux = 32'(dout_q);
    end else if (sel_acfg) begin
      rd_mux = 32'(ao_cfg_q);
    end else if (sel_aval0) begin
      rd_mux = 32'(ao_val_q[0]);
    end else if (sel_aval1) begin
      rd_mux = 32'(ao_val_q[1]);
    end else if (sel_gain) begin
      rd_mux = 32'(gain_q);
    end else if (sel_src) begin
      rd_mux = 32'(src_q);
    end else if (sel_atrim) begin
      rd_mux = {trim_q[3], trim_q[2], trim_q[1], trim_q[0]};
    end else if (sel_dtrim) begin
      rd_mux = {trim_q[7], trim_q[6], trim_q[5], trim_q[4]};
    end else if (sel_nv) begin
      rd_mux = {29'h0, nv_loaded_q, nv_st_q == ECG_NV_SAVE, nv_busy};
    end
  end

  // data is valid only in the cycle after the read strobe
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= '0;
    end else if (rd_i) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= '0;
    end
  end

  // ---------------------------------------------------------------
  // outputs straight from flops, except nv_we_o and nv_wdata_o decoded from sequencer flops
  assign rdata_o          = rdata_q;
  assign fb_valid_o       = fb_valid_q;
  assign fb_axis_o        = fb_axis_q;
  assign fb_position_o    = fb_pos_q;
  assign fb_resolution_o  = fb_res_q;
  assign dout_o           = dout_q;
  assign ao_code_o        = {ao_code_q[1], ao_code_q[0]};
  assign ad_gain_o        = gain_q;
  assign self_check_src_o = src_q;
  assign ao_trim_o        = {trim_q[3], trim_q[2], trim_q[1], trim_q[0]};
  assign ad_trim_o        = {trim_q[7], trim_q[6], trim_q[5], trim_q[4]};
  assign nv_req_o         = nv_req_q;
  assign nv_we_o          = (nv_st_q == ECG_NV_SAVE);
  assign nv_addr_o        = nv_idx_q;
  assign nv_wdata_o       = trim_q[nv_idx_q];

endmodule

// ===== dv/ecg_unit_sva.sv
// ecg_unit_sva: port-level checks of the register port and trim store walk.
// assumes one clock domain, reset active low and asynchronous.
`timescale 1ns/1ps
module ecg_unit_sva import ecg_pkg::*; (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rstn_i,
  // register port
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  // observed outputs
  input wire logic [1:0]  dout_o,
  input wire logic [1:0]  self_check_src_o,
  input wire logic [31:0] fb_resolution_o,
  input wire logic [3:0]  ad_gain_o,
  // nonvolatile handshake
  input wire logic        nv_req_o,
  input wire logic        nv_we_o,
  input wire logic [2:0]  nv_addr_o,
  input wire logic        nv_ack_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // read data only in the cycle after a read strobe
  a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero outside read cycle");
  // request is a level held until the memory answers
  a_nv_req_hold: assert property (nv_req_o && !nv_ack_i |=> nv_req_o)
    else $error("trim store request dropped before ack");
  a_nv_addr_step: assert property (nv_req_o && nv_ack_i && nv_addr_o != 3'h7 |=>
    nv_req_o && nv_addr_o == 3'($past(nv_addr_o) + 3'h1))
    else $error("trim store byte index did not advance");
  a_nv_walk_end: assert property (nv_req_o && nv_ack_i && nv_addr_o == 3'h7 |=> !nv_req_o)
    else $error("trim store walk did not end after last byte");
  a_nv_dir_steady: assert property (nv_req_o && !nv_ack_i |=> $stable(nv_we_o))
    else $error("trim store direction changed mid request");
  a_dout_follow_write: assert property (wr_i && addr_i == ECG_DOUT_OFS |=>
    dout_o == $past(wdata_i[1:0]))
    else $error("isolated outputs not set by write");
  a_self_src_write: assert property (wr_i && addr_i == ECG_SELF_SRC_OFS |=>
    self_check_src_o == $past(wdata_i[1:0]))
    else $error("self check source not set by write");
  a_fb_res_write: assert property (wr_i && addr_i == ECG_FB_RES_OFS |=>
    fb_resolution_o == $past(wdata_i))
    else $error("feedback resolution not set by write");
  a_gain_lane_write: assert property (wr_i && addr_i == ECG_AD_GAIN_OFS
    && wdata_i[1:0] != 2'h3 |=> ad_gain_o[1:0] == $past(wdata_i[1:0]))
    else $error("input gain lane not set by write");
endmodule

bind ecg_unit ecg_unit_sva ecg_unit_sva_inst (
  .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .dout_o(dout_o), .self_check_src_o(self_check_src_o),
  .fb_resolution_o(fb_resolution_o), .ad_gain_o(ad_gain_o), .nv_req_o(nv_req_o),
  .nv_we_o(nv_we_o), .nv_addr_o(nv_addr_o), .nv_ack_i(nv_ack_i)
);

// ===== dv/ecg_enc_model.sv
// ecg_enc_model: external encoder / driver feedback for three channels.
// assumes one command pulse per step, commands at least four cycles apart.
`timescale 1ns/1ps
module ecg_enc_model import ecg_pkg::*; (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // step command
  input  wire logic       go_i,
  input  wire logic [1:0] chan_i,
  input  wire logic       up_i,
  input  wire logic       idx_i,
  input  wire logic [1:0] mode_i,
  // encoder lines, driven all the time
  output logic [2:0]      first_o,
  output logic [2:0]      second_o,
  output logic [2:0]      index_o
);
  logic [1:0] ph_q;
  logic [1:0] ch_q;
  logic [1:0] md_q;
  logic       up_q;
  logic       idx_q;

  // three phase step sequencer; lines stay low at reset so release gives no edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {first_o, second_o, index_o} <= '0;
      {ph_q, ch_q, md_q, up_q, idx_q} <= '0;
    end else if (go_i) begin
      {ph_q, ch_q, md_q, up_q, idx_q} <= {2'h1, chan_i, mode_i, up_i, idx_i};
    end else if (ph_q != 2'h0) begin
      ph_q <= (ph_q == 2'h3) ? 2'h0 : ph_q + 2'h1;
      if (idx_q) begin
        index_o[ch_q] <= (ph_q == 2'h1);
      end else if (md_q == ECG_MODE_QUAD) begin
        // one gray step, first leads second when going up
        if (ph_q == 2'h1) begin
          first_o[ch_q]  <= up_q ? ~second_o[ch_q] : second_o[ch_q];
          second_o[ch_q] <= up_q ? first_o[ch_q] : ~first_o[ch_q];
        end
      end else if (md_q == ECG_MODE_DUAL) begin
        if (up_q) first_o[ch_q] <= (ph_q == 2'h1);
        else second_o[ch_q] <= (ph_q == 2'h1);
      end else begin
        // direction settles a cycle before the count pulse
        if (ph_q == 2'h1) second_o[ch_q] <= up_q;
        else first_o[ch_q] <= (ph_q == 2'h2);
      end
    end
  end
endmodule

// ===== dv/ecg_unit_tb.sv
// ecg_unit_tb: register-level tests of the encoder counter / gpio unit.
// assumes the strobe register port and a one-cycle ack trim memory.
`timescale 1ns/1ps
module ecg_unit_tb;
  import ecg_pkg::*;
  logic        clk_i, rstn_i, wr_i, rd_i, go, up, idx, nv_ack_i;
  logic [7:0]  addr_i, nv_rdata_i;
  logic [31:0] wdata_i, rdata_o, cmd_vel_i, ao_code_o, ao_trim_o, ad_trim_o;
  logic [31:0] fb_position_o, fb_resolution_o;
  logic [2:0]  fst, snd, zix, nv_addr_o;
  logic [1:0]  ch, md, din_i, dout_o, self_check_src_o;
  logic [3:0]  fb_axis_o, ad_gain_o;
  logic        fb_valid_o, nv_req_o, nv_we_o;
  logic [7:0]  nv_wdata_o;
  logic [7:0]  mem [8];
  logic [15:0] vin [4] = '{16'h0BB8, 16'hF448, 16'h0FA0, 16'h05DC};
  logic [15:0] vexp [4] = '{16'h7FFF, 16'h8001, 16'h7FFF, 16'h3FFF};
  int          bad_count, tests_run, cyc;

  ecg_unit ecg_unit_inst (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .count_input_first_i(fst),
    .count_input_second_i(snd), .index_input_i(zix), .fb_valid_o(fb_valid_o),
    .fb_axis_o(fb_axis_o), .fb_position_o(fb_position_o), .fb_resolution_o(fb_resolution_o),
    .din_i(din_i), .dout_o(dout_o), .cmd_vel_i(cmd_vel_i), .ao_code_o(ao_code_o),
    .ad_gain_o(ad_gain_o), .self_check_src_o(self_check_src_o), .ao_trim_o(ao_trim_o),
    .ad_trim_o(ad_trim_o), .nv_req_o(nv_req_o), .nv_we_o(nv_we_o), .nv_addr_o(nv_addr_o),
    .nv_wdata_o(nv_wdata_o), .nv_ack_i(nv_ack_i), .nv_rdata_i(nv_rdata_i));
  ecg_enc_model ecg_enc_model_inst (.clk_i(clk_i), .rstn_i(rstn_i), .go_i(go), .chan_i(ch),
    .up_i(up), .idx_i(idx), .mode_i(md), .first_o(fst), .second_o(snd), .index_o(zix));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // trim memory: one-cycle ack, answers every request byte
  always @(posedge clk_i) begin
    nv_ack_i   <= nv_req_o & ~nv_ack_i;
    nv_rdata_i <= mem[nv_addr_o];
    if (nv_ack_i && nv_req_o && nv_we_o) mem[nv_addr_o] <= nv_wdata_o;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk_i);
    {rd_i, addr_i} <= {1'b1, a};
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(n, e, rdata_o);
  endtask
  // one encoder step or index pulse, then let the count settle
  task automatic enc(input logic [1:0] c, input logic [1:0] m, input logic u, input logic z);
    @(posedge clk_i);
    {go, ch, md, up, idx} <= {1'b1, c, m, u, z};
    @(posedge clk_i);
    go <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic wrap_up();
    $display("counts: tests_run %0d bad_count %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    // memory answer lines and the cycle count belong to the memory process alone
    {rstn_i, wr_i, rd_i, go, up, idx, addr_i, wdata_i, ch, md} = '0;
    {bad_count, tests_run, cmd_vel_i} = '0;
    din_i = 2'b10;
    for (int i = 0; i < 8; i++) mem[i] = 8'h10 + 8'(i);
    repeat (5) @(posedge clk_i);
    chk("trim at reset", 32'h8080_8080, ao_trim_o);
    chk("in trim at reset", 32'h8080_8080, ad_trim_o);
    @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    // start-up reload of all eight trims
    rd(ECG_NV_CTRL_OFS, 32'h4, "nv status");
    chk("out trims", 32'h1312_1110, ao_trim_o);
    chk("in trims", 32'h1716_1514, ad_trim_o);
    rd(ECG_DA_CFG_OFS, 32'h0, "ao mode");
    // counter 0 quad, 1 dual pulse, 2 pulse with direction
    wr(ECG_MODE_OFS, 32'h24);
    wr(ECG_CNT0_OFS, 32'd100);
    rd(ECG_CNT0_OFS, 32'd100, "count load");
    repeat (4) enc(2'd0, ECG_MODE_QUAD, 1'b1, 1'b0);
    rd(ECG_CNT0_OFS, 32'd104, "quad up");
    repeat (2) enc(2'd0, ECG_MODE_QUAD, 1'b0, 1'b0);
    rd(ECG_CNT0_OFS, 32'd102, "quad down");
    repeat (3) enc(2'd1, ECG_MODE_DUAL, 1'b1, 1'b0);
    enc(2'd1, ECG_MODE_DUAL, 1'b0, 1'b0);
    rd(ECG_CNT1_OFS, 32'd2, "dual pulse");
    repeat (2) enc(2'd2, ECG_MODE_PDIR, 1'b1, 1'b0);
    enc(2'd2, ECG_MODE_PDIR, 1'b0, 1'b0);
    rd(ECG_CNT2_OFS, 32'd1, "pulse dir");
    // feedback assignment of counter 0 to axis 5
    wr(ECG_FB_RES_OFS, 32'd10000);
    wr(ECG_FB_SEL_OFS, 32'h150);
    repeat (2) @(posedge clk_i);
    chk("fb valid", 32'h1, 32'(fb_valid_o));
    chk("fb axis", 32'h5, 32'(fb_axis_o));
    chk("fb res", 32'd10000, fb_resolution_o);
    chk("fb pos", 32'd102, fb_position_o);
    enc(2'd0, ECG_MODE_QUAD, 1'b0, 1'b1);
    rd(ECG_CNT0_OFS, 32'h0, "index clear");
    chk("fb pos idx", 32'h0, fb_position_o);
    wr(ECG_FB_SEL_OFS, 32'h153);
    repeat (2) @(posedge clk_i);
    chk("fb bad sel", 32'h0, 32'(fb_valid_o));
    // mode code 11 on counter 0 must hold its value against a quad step
    wr(ECG_MODE_OFS, 32'h27);
    enc(2'd0, ECG_MODE_QUAD, 1'b1, 1'b0);
    rd(ECG_CNT0_OFS, 32'h0, "no count mode");
    // isolated io
    rd(ECG_DIN_OFS, 32'h2, "din");
    wr(ECG_DOUT_OFS, 32'h3);
    wr(ECG_DOUT_OFS, 32'h1);
    @(negedge clk_i);
    chk("dout", 32'h1, 32'(dout_o));
    // analog out: ch0 direct, ch1 velocity scaled and clamped
    wr(ECG_DA_VAL0_OFS, 32'h1234);
    wr(ECG_DA_CFG_OFS, 32'h2);
    for (int i = 0; i < 4; i++) begin
      cmd_vel_i <= {vin[i], 16'h0};
      repeat (3) @(posedge clk_i);
      chk("ao vel", 32'(vexp[i]), 32'(ao_code_o[31:16]));
      chk("ao direct", 32'h1234, 32'(ao_code_o[15:0]));
    end
    // gain lanes, code 11 refused
    wr(ECG_AD_GAIN_OFS, 32'h9);
    wr(ECG_AD_GAIN_OFS, 32'hE);
    @(negedge clk_i);
    chk("gain", 32'hA, 32'(ad_gain_o));
    for (int i = 0; i < 4; i++) begin
      wr(ECG_SELF_SRC_OFS, 32'(i));
      @(negedge clk_i);
      chk("self src", 32'(i), 32'(self_check_src_o));
    end
    // trim steps, then save to memory
    wr(ECG_DA_TRIM_OFS, 32'h180);
    wr(ECG_DA_TRIM_OFS, 32'h380);
    wr(ECG_DA_TRIM_OFS, 32'h05A);
    wr(ECG_DA_TRIM_OFS, 32'h23C);
    rd(ECG_DA_TRIM_OFS, 32'h803C_805A, "trim read");
    wr(ECG_NV_CTRL_OFS, 32'h1);
    repeat (40) @(posedge clk_i);
    chk("saved out", 32'h803C_805A, {mem[3], mem[2], mem[1], mem[0]});
    chk("saved in", 32'h1716_1514, {mem[7], mem[6], mem[5], mem[4]});
    // spoil step 0, then a reload command must bring the saved byte back
    wr(ECG_DA_TRIM_OFS, 32'h011);
    wr(ECG_NV_CTRL_OFS, 32'h2);
    repeat (40) @(posedge clk_i);
    chk("reloaded out", 32'h803C_805A, ao_trim_o);
    rd(8'h40, 32'h0, "unmapped");
    wrap_up();
  end
endmodule
